// ---- rtl/wdt_consts.vh ----
// Register map, field positions, reset values and timing counts of the watchdog reset unit.
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH

// ****************************************************************
// Register offsets (word addresses, one word each)
// ****************************************************************
`define OFS_WATCHDOG_CONTROL  4'h0
`define OFS_RESET_CAUSE_FLAGS 4'h1
`define OFS_STATUS_FLAGS      4'h2
`define OFS_IRQ_STATUS        4'h3
`define OFS_IRQ_ENABLE        4'h4
`define OFS_IRQ_CLEAR         4'h5
`define OFS_CORE_EVENT        4'h6

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define GUARD_MSB             7
`define GUARD_LSB             3
`define SEL_MSB               2
`define SEL_LSB               0
`define GUARD_LEGAL_A         5'h15
`define GUARD_LEGAL_B         5'h0a
`define WATCHDOG_CONTROL_RST  8'h53
`define RESET_CAUSE_FLAGS_RST 8'h00
`define BIT_EXPIRY            0
`define BIT_POWERDOWN         1
`define BIT_CLR_INSTR         0
`define BIT_HALT_INSTR        1
`define BIT_SLEEP_MODE        2
`define IRQ_OVERFLOW          0
`define IRQ_GUARD_RESET       1

// ****************************************************************
// Timing
// ****************************************************************
`define SOFT_RESET_DELAY      16

`endif

// ---- rtl/wdt_sync2.v ----
// Two-stage synchroniser for a single level.
`timescale 1ns/100ps
`default_nettype none
module wdt_sync2 (
  input  wire clock,
  input  wire reset,
  input  wire din,
  output reg  dout
);
  reg stage1;

  always @(posedge clock) begin
    if (reset) begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/watchdog_reset_unit.v ----
// Watchdog timer with guard field, soft reset, reset flags and Avalon-MM registers.
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "wdt_consts.vh"
module watchdog_reset_unit #(
  parameter integer RESET_DELAY = `SOFT_RESET_DELAY
) (
  input  wire        CLOCK,
  input  wire        RESET,
  input  wire        LOW_SPEED_CLOCK,
  input  wire        WATCHDOG_CLEAR_INSTRUCTION,
  input  wire        HALT_INSTRUCTION,
  input  wire        SLEEP_MODE,
  input  wire [3:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  input  wire [3:0]  AVS_BYTEENABLE,
  output reg  [31:0] AVS_READDATA,
  output reg         AVS_WAITREQUEST,
  output reg         DEVICE_RESET,
  output reg         PC_SP_CLEAR,
  output reg         PORT_PRESET,
  output reg         IRQ
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function [4:0] tap_exponent;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    tap_exponent = 5'h08;
        3'h1:    tap_exponent = 5'h0a;
        3'h2:    tap_exponent = 5'h0c;
        3'h3:    tap_exponent = 5'h0e;
        3'h4:    tap_exponent = 5'h0f;
        3'h5:    tap_exponent = 5'h10;
        3'h6:    tap_exponent = 5'h11;
        default: tap_exponent = 5'h12;
      endcase
    end
  endfunction

  function guard_legal;
    input [4:0] g;
    begin
      guard_legal = (g == `GUARD_LEGAL_A) || (g == `GUARD_LEGAL_B);
    end
  endfunction

  // One decode serves every write strobe, so a change of the map touches
  // a single place.
  function reg_hit;
    input [3:0] addr;
    input [3:0] offset;
    begin
      reg_hit = (addr == offset);
    end
  endfunction

  // ****************************************************************
  // Oscillator edge detection
  // ****************************************************************
  // The oscillator is asynchronous, so it is synchronised and its rising
  // edges become single-cycle ticks of the system clock.
  wire       osc_sync;
  reg        osc_prev;
  wire       osc_tick;

  wdt_sync2 u_osc_sync (
    .clock (CLOCK),
    .reset (RESET),
    .din   (LOW_SPEED_CLOCK),
    .dout  (osc_sync)
  );

  always @(posedge CLOCK) begin
    if (RESET) begin
      osc_prev <= 1'b0;
    end else begin
      osc_prev <= osc_sync;
    end
  end

  assign osc_tick = osc_sync & ~osc_prev;

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  reg  [7:0]  watchdog_control;
  reg         control_reset_flag;
  reg         expiry_flag;
  reg         powerdown_flag;
  reg  [18:0] count;
  reg  [1:0]  irq_status;
  reg  [1:0]  irq_enable;
  reg  [15:0] delay_count;
  reg         delay_run;
  reg         post_reset;
  reg  [18:0] next_count;
  reg  [31:0] next_readdata;

  // Only byte lane zero carries register data; the upper lanes are ignored
  // on writes and read back as zero.
  wire        acc = AVS_READ | AVS_WRITE;
  wire        wr = AVS_WRITE & ~AVS_WAITREQUEST & AVS_BYTEENABLE[0];
  wire        wr_ctrl = wr && reg_hit(AVS_ADDRESS, `OFS_WATCHDOG_CONTROL);
  wire        wr_core = wr && reg_hit(AVS_ADDRESS, `OFS_CORE_EVENT);
  wire        wr_flags = wr && reg_hit(AVS_ADDRESS, `OFS_RESET_CAUSE_FLAGS);
  wire        wr_irq_enable = wr && reg_hit(AVS_ADDRESS, `OFS_IRQ_ENABLE);
  wire        wr_irq_clear = wr && reg_hit(AVS_ADDRESS, `OFS_IRQ_CLEAR);
  wire        clr_instr = WATCHDOG_CLEAR_INSTRUCTION |
                          (wr_core & AVS_WRITEDATA[`BIT_CLR_INSTR]);
  wire        halt_instr = HALT_INSTRUCTION | (wr_core & AVS_WRITEDATA[`BIT_HALT_INSTR]);
  wire        sleeping = SLEEP_MODE | (wr_core & AVS_WRITEDATA[`BIT_SLEEP_MODE]);
  wire [4:0]  guard_field = watchdog_control[`GUARD_MSB:`GUARD_LSB];
  wire [2:0]  timeout_select = watchdog_control[`SEL_MSB:`SEL_LSB];
  wire        guard_bad = ~guard_legal(guard_field);
  wire        guard_bad_write = wr_ctrl && !guard_legal(AVS_WRITEDATA[7:3]);
  // The limit is one below the period because a clear restarts the count at
  // zero. Greater-or-equal lets a shortened timeout expire on the next tick
  // rather than after a wrap through the full counter width.
  wire [18:0] limit = (19'h00001 << tap_exponent(timeout_select)) - 19'h00001;
  wire        overflow = osc_tick && (count >= limit) && !guard_bad;
  wire        delay_done = delay_run && (delay_count == RESET_DELAY[15:0] - 16'h0001);
  // A full reset comes from the end of the soft-reset delay or from an
  // overflow while running; an overflow in sleep never resets the device.
  wire        full_reset = delay_done | (overflow & ~sleeping);

  // ****************************************************************
  // Watchdog counter
  // ****************************************************************
  // Counting pauses while the guard is illegal; the pending soft reset
  // decides the outcome then, not the timeout.
  always @* begin
    next_count = count;
    if (full_reset) begin
      next_count = 19'h00000;
    end else if (guard_bad_write || clr_instr || halt_instr || overflow) begin
      next_count = 19'h00000;
    end else if (osc_tick && !guard_bad) begin
      next_count = count + 19'h00001;
    end
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      count <= 19'h00000;
    end else begin
      count <= next_count;
    end
  end

  // ****************************************************************
  // Soft reset delay on an illegal guard value
  // ****************************************************************
  // The guard is checked continuously, so a disturbed value is caught as
  // well as a written one.
  // Once started the delay always runs out, even if software restores a
  // legal pattern meanwhile, because the reset is already committed.
  always @(posedge CLOCK) begin
    if (RESET || delay_done) begin
      delay_run   <= 1'b0;
      delay_count <= 16'h0000;
    end else if (delay_run) begin
      delay_count <= delay_count + 16'h0001;
    end else if (guard_bad) begin
      delay_run <= 1'b1;
    end
  end

  // ****************************************************************
  // Control register and flags
  // ****************************************************************
  always @(posedge CLOCK) begin
    if (RESET) begin
      watchdog_control   <= `WATCHDOG_CONTROL_RST;
      control_reset_flag <= 1'b0;
      expiry_flag        <= 1'b0;
      powerdown_flag     <= 1'b0;
    end else begin
      if (delay_done) begin
        watchdog_control <= `WATCHDOG_CONTROL_RST;
      end else if (wr_ctrl) begin
        watchdog_control <= AVS_WRITEDATA[7:0];
      end
      // Setting wins over a software clear in the same cycle.
      if (delay_done) begin
        control_reset_flag <= 1'b1;
      end else if (wr_flags && !AVS_WRITEDATA[0]) begin
        control_reset_flag <= 1'b0;
      end
      if (overflow) begin
        expiry_flag <= 1'b1;
      end else if (halt_instr) begin
        expiry_flag <= 1'b0;
      end
      // An overflow keeps the powerdown flag, so software can tell a timeout
      // out of sleep from one in normal running by reading both flags.
      if (overflow) begin
        powerdown_flag <= powerdown_flag;
      end else if (halt_instr) begin
        powerdown_flag <= 1'b1;
      end else if (clr_instr) begin
        powerdown_flag <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Interrupt status, enable and clear
  // ****************************************************************
  wire [1:0] irq_set = {delay_done, overflow};
  // Status bits are sticky and a new event wins over a clear in the same
  // cycle, so no event is lost to a badly timed clear.
  wire [1:0] irq_clr = wr_irq_clear ? AVS_WRITEDATA[1:0] : 2'h0;

  always @(posedge CLOCK) begin
    if (RESET) begin
      irq_status <= 2'h0;
      irq_enable <= 2'h0;
      IRQ        <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
      if (wr_irq_enable) begin
        irq_enable <= AVS_WRITEDATA[1:0];
      end
      IRQ <= |(irq_status & irq_enable);
    end
  end

  // ****************************************************************
  // Reset outputs
  // ****************************************************************
  // Power-on reset raises the core and port presets for one cycle after
  // release so the core sees them as a pulse on its own clock.
  // A sleep overflow pulses only the program counter and stack pointer
  // clear; ports and registers keep their state then.
  always @(posedge CLOCK) begin
    if (RESET) begin
      post_reset   <= 1'b1;
      DEVICE_RESET <= 1'b1;
      PC_SP_CLEAR  <= 1'b1;
      PORT_PRESET  <= 1'b1;
    end else begin
      post_reset   <= 1'b0;
      DEVICE_RESET <= full_reset | post_reset;
      PC_SP_CLEAR  <= full_reset | post_reset | (overflow & sleeping);
      PORT_PRESET  <= full_reset | post_reset;
    end
  end

  // ****************************************************************
  // Avalon-MM slave
  // ****************************************************************
  // Write-only and unmapped offsets read as zero; writes to unmapped
  // offsets are dropped.
  always @* begin
    case (AVS_ADDRESS)
      `OFS_WATCHDOG_CONTROL:  next_readdata = {24'h000000, watchdog_control};
      `OFS_RESET_CAUSE_FLAGS: next_readdata = {31'h00000000, control_reset_flag};
      `OFS_STATUS_FLAGS:      next_readdata = {30'h00000000, powerdown_flag, expiry_flag};
      `OFS_IRQ_STATUS:        next_readdata = {30'h00000000, irq_status};
      `OFS_IRQ_ENABLE:        next_readdata = {30'h00000000, irq_enable};
      default:                next_readdata = 32'h00000000;
    endcase
  end

  // Every access takes two cycles: waitrequest drops one cycle after the
  // request and data is valid at that edge.
  always @(posedge CLOCK) begin
    if (RESET) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h00000000;
    end else begin
      AVS_WAITREQUEST <= ~(acc & AVS_WAITREQUEST);
      if (AVS_READ && AVS_WAITREQUEST) begin
        AVS_READDATA <= next_readdata;
      end
    end
  end

endmodule
`default_nettype wire

// ---- verification/wdt_monitor.sv ----
// Port assertions for the watchdog reset unit.
`timescale 1ns/100ps
`default_nettype none
module wdt_monitor #(
  parameter int RESET_DELAY = 16
) (
  input wire logic        CLOCK,
  input wire logic        RESET,
  input wire logic [3:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        DEVICE_RESET,
  input wire logic        PC_SP_CLEAR,
  input wire logic        SLEEP_MODE,
  input wire logic        IRQ
);
  localparam int GMAX = RESET_DELAY + 6;
  logic       taken;
  logic [3:0] addr;
  logic       wr;
  assign wr = AVS_WRITE && !AVS_WAITREQUEST;
  always @(posedge CLOCK) begin
    taken <= AVS_READ && AVS_WAITREQUEST && !RESET;
    addr  <= AVS_ADDRESS;
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  chk_wait_one: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("no answer");
  chk_wait_drop: assert property (
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("answer too long");
  chk_flags_upper: assert property (
    taken && addr == 4'h1 |-> AVS_READDATA[31:1] == 31'h0) else $error("flag bits set");
  chk_unmapped_zero: assert property (
    taken && addr > 4'h6 |-> AVS_READDATA == 32'h0) else $error("unmapped data");
  chk_reset_pulse: assert property (
    $rose(DEVICE_RESET) |=> !DEVICE_RESET) else $error("long reset pulse");
  chk_sleep_clear: assert property (
    $rose(PC_SP_CLEAR) && $past(SLEEP_MODE) |-> !DEVICE_RESET ##1 !PC_SP_CLEAR)
    else $error("bad sleep clear");
  chk_reset_clears_pc: assert property (
    DEVICE_RESET |-> PC_SP_CLEAR) else $error("reset without pc clear");
  chk_guard_delay: assert property (
    wr && AVS_ADDRESS == 4'h0 && AVS_WRITEDATA[7:3] != 5'h15 && AVS_WRITEDATA[7:3] != 5'h0a
    |-> ##[3:GMAX] DEVICE_RESET) else $error("guard reset timing");
  chk_irq_mask: assert property (
    wr && AVS_ADDRESS == 4'h4 && AVS_WRITEDATA[1:0] == 2'h0 |-> ##2 !IRQ) else $error("irq");
endmodule
bind watchdog_reset_unit wdt_monitor #(.RESET_DELAY(RESET_DELAY)) mon (
  .CLOCK(CLOCK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .DEVICE_RESET(DEVICE_RESET),
  .PC_SP_CLEAR(PC_SP_CLEAR), .SLEEP_MODE(SLEEP_MODE), .IRQ(IRQ));
`default_nettype wire

// ---- verification/core_model.sv ----
// Processor core model with the low-speed oscillator beside it.
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input  wire logic clock,
  input  wire logic service,
  input  wire logic halt_req,
  input  wire logic sleep_req,
  output logic      osc,
  output logic      clear_pulse,
  output logic      halt_pulse,
  output logic      sleep_mode
);
  logic [1:0] div;
  logic [6:0] gap;
  logic       halt_seen;
  initial {div, gap, halt_seen, osc, clear_pulse, halt_pulse, sleep_mode} = '0;
  // The oscillator runs at a quarter of the clock so a 2^8 timeout fits a short run.
  always @(posedge clock) begin
    div         <= div + 2'd1;
    osc         <= div[1];
    gap         <= (gap == 7'd99) ? 7'd0 : gap + 7'd1;
    // A kick every 100 clocks stays far inside 256 oscillator periods.
    clear_pulse <= service && gap == 7'd0;
    halt_seen   <= halt_req;
    halt_pulse  <= halt_req && !halt_seen;
    sleep_mode  <= sleep_req;
  end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the watchdog reset unit.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int DLY = 4;
  logic        CLOCK, RESET, AVS_READ, AVS_WRITE, service, halt_req, sleep_req;
  logic [3:0]  AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, seed, q;
  wire  [31:0] AVS_READDATA;
  wire         AVS_WAITREQUEST, DEVICE_RESET, PC_SP_CLEAR, PORT_PRESET, IRQ, osc, clr, hlt, slp;
  int          fail_count, check_count, rst_n, pc_n, pp_n, b0, b1, b2;
  watchdog_reset_unit #(.RESET_DELAY(DLY)) uut (
    .CLOCK(CLOCK), .RESET(RESET), .LOW_SPEED_CLOCK(osc), .WATCHDOG_CLEAR_INSTRUCTION(clr),
    .HALT_INSTRUCTION(hlt), .SLEEP_MODE(slp), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ),
    .DEVICE_RESET(DEVICE_RESET), .PC_SP_CLEAR(PC_SP_CLEAR), .PORT_PRESET(PORT_PRESET));
  core_model core (.clock(CLOCK), .service(service), .halt_req(halt_req), .sleep_req(sleep_req),
    .osc(osc), .clear_pulse(clr), .halt_pulse(hlt), .sleep_mode(slp));
  function logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function logic [31:0] ctl(input logic [31:0] r);
    return {24'h0, r[0] ? 5'h15 : 5'h0a, r[3:1]};
  endfunction
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge CLOCK);
    AVS_READ      <= !w;
    AVS_WRITE     <= w;
    AVS_ADDRESS   <= a;
    AVS_WRITEDATA <= d;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
    q = AVS_READDATA;
    if (AVS_WAITREQUEST !== 1'b0) fail_count++;
    AVS_READ  <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check("readdata", q, e);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge CLOCK) begin
    if (!RESET && DEVICE_RESET === 1'b1) rst_n++;
    if (!RESET && PC_SP_CLEAR === 1'b1) pc_n++;
    if (!RESET && PORT_PRESET === 1'b1) pp_n++;
  end
  initial begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end
  initial begin
    #100000;
    fail_count++;
    print_verdict;
  end
  initial begin
    {RESET, AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA} = {1'b1, 38'h0};
    {service, halt_req, sleep_req, seed} = {3'h0, 32'h8e37};
    {fail_count, check_count, rst_n, pc_n, pp_n} = '0;
    cyc(2);
    check("reset_outs", {PORT_PRESET, PC_SP_CLEAR}, 2'h3);
    RESET <= 1'b0;
    rd(4'h0, 32'h53);
    rd(4'h1, 32'h0);
    rd(4'h2, 32'h0);
    rd(4'h7, 32'h0);
    bus(1'b1, 4'h4, 32'h3);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      bus(1'b1, 4'h0, ctl(seed));
      rd(4'h0, ctl(seed));
    end
    bus(1'b1, 4'h0, 32'h50);
    service <= 1'b1;
    b0 = rst_n;
    cyc(3000);
    check("kept_alive", rst_n - b0, 0);
    service  <= 1'b0;
    halt_req <= 1'b1;
    cyc(1000);
    check("early", rst_n - b0, 0);
    halt_req <= 1'b0;
    cyc(60);
    check("overflow", rst_n - b0, 1);
    check("irq", IRQ, 1'b1);
    rd(4'h2, 32'h3);
    rd(4'h3, 32'h1);
    bus(1'b1, 4'h5, 32'h1);
    cyc(3);
    check("irq_clear", IRQ, 1'b0);
    bus(1'b1, 4'h6, 32'h1);
    rd(4'h2, 32'h1);
    halt_req  <= 1'b1;
    sleep_req <= 1'b1;
    cyc(3);
    rd(4'h2, 32'h2);
    b0 = rst_n;
    b1 = pc_n;
    b2 = pp_n;
    cyc(1060);
    check("sleep_reset", rst_n - b0, 0);
    check("sleep_ports", pp_n - b2, 0);
    check("pc_sp_clear", pc_n - b1, 1);
    rd(4'h2, 32'h3);
    sleep_req <= 1'b0;
    halt_req  <= 1'b0;
    bus(1'b1, 4'h5, 32'h3);
    b0 = rst_n;
    b2 = pp_n;
    bus(1'b1, 4'h0, 32'h0);
    cyc(DLY + 10);
    check("guard_reset", rst_n - b0, 1);
    check("guard_ports", pp_n - b2, 1);
    rd(4'h1, 32'h1);
    rd(4'h0, 32'h53);
    rd(4'h3, 32'h2);
    bus(1'b1, 4'h1, 32'h0);
    rd(4'h1, 32'h0);
    bus(1'b1, 4'h4, 32'h0);
    cyc(3);
    check("irq_mask", IRQ, 1'b0);
    print_verdict;
  end
endmodule
`default_nettype wire
